/* verilog/eiaf_regs.svh */
// Constants of the assembly framer: register map, object codes, image sizes.
// Assumes inclusion by bare name from any framer source file.
`ifndef EIAF_REGS_SVH
`define EIAF_REGS_SVH
// Register offsets
`define EIAF_A_CTRL    8'h00
`define EIAF_A_STAT    8'h04
`define EIAF_A_ISTAT   8'h08
`define EIAF_A_IMASK   8'h0c
`define EIAF_A_CFG0    8'h10
`define EIAF_A_CFG1    8'h14
`define EIAF_A_CFG2    8'h18
// Control bit and reset value
`define EIAF_CTRL_EN   0
`define EIAF_CTRL_RST  1'h1
// Interrupt status bits
`define EIAF_IRQ_ACC   0
`define EIAF_IRQ_REJ   1
`define EIAF_IRQ_DROP  2
`define EIAF_IRQ_BAD   3
`define EIAF_IRQ_W     4
// Object codes
`define EIAF_SVC_GET   8'h0e
`define EIAF_CLS_ASM   8'h04
`define EIAF_ATTR_REV  8'h01
`define EIAF_ATTR_MAXI 8'h02
`define EIAF_ATTR_DATA 8'h03
`define EIAF_INST_CLS  8'h00
`define EIAF_INST_POS  8'h01
`define EIAF_INST_FLG  8'h02
`define EIAF_INST_VEL  8'h03
`define EIAF_INST_CFG  8'h6a
`define EIAF_PT_INONLY 8'h64
`define EIAF_PT_LISTEN 8'h65
`define EIAF_REV_VAL   16'h0002
`define EIAF_MAXI_VAL  16'h0096
// Image lengths in bytes
`define EIAF_LEN_POS   4'h4
`define EIAF_LEN_FLG   4'h5
`define EIAF_LEN_VEL   4'h8
`define EIAF_LEN_CFG   4'hc
`define EIAF_LEN_WORD  4'h2
// Flag byte fields
`define EIAF_FLG_ALARM 0
`define EIAF_FLG_WARN  1
// Answer status codes
`define EIAF_ST_OK     8'h00
`define EIAF_ST_NOSVC  8'h08
`define EIAF_ST_NOATTR 8'h14
`define EIAF_ST_NOOBJ  8'h16
// Configuration image
`define EIAF_CFG_RSV   4'ha
`define EIAF_CFG_RST   96'h0000_0000_0000_0000_0000_0100
`define EIAF_LO_MAX    2'h3
`endif

/* verilog/eiaf_pkg.sv */
// Types of the assembly framer.
// Assumes eiaf_regs.svh on the include path.
`default_nettype none
`include "eiaf_regs.svh"
package eiaf_pkg;
  // Image selected for an answer
  typedef enum logic [2:0] {SEL_POS, SEL_FLG, SEL_VEL, SEL_CFG, SEL_REV, SEL_MAXI} eiaf_sel_t;
  // Request engine states
  typedef enum logic {ST_IDLE, ST_SEND} eiaf_st_t;
  // Byte count of each image
  function automatic logic [3:0] eiaf_len(input eiaf_sel_t s);
    case (s)
      SEL_POS: eiaf_len = `EIAF_LEN_POS;
      SEL_FLG: eiaf_len = `EIAF_LEN_FLG;
      SEL_VEL: eiaf_len = `EIAF_LEN_VEL;
      SEL_CFG: eiaf_len = `EIAF_LEN_CFG;
      default: eiaf_len = `EIAF_LEN_WORD;
    endcase
  endfunction : eiaf_len
endpackage : eiaf_pkg
`default_nettype wire

/* verilog/eiaf_img_if.sv */
// Link between request engine and image serializer.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface eiaf_img_if import eiaf_pkg::*;;
  logic             start;   // One-cycle start pulse
  eiaf_sel_t        sel;     // Image to send
  logic [31:0]      pos;     // Live position
  logic [31:0]      vel;     // Live velocity
  logic             alarm;   // Live alarm flag
  logic             warn;    // Live warning flag
  logic [95:0]      cfg;     // Configuration image
  logic             bvalid;  // Byte valid
  logic [7:0]       bdata;   // Byte data
  logic             blast;   // Last byte
  modport ctl (output start, sel, pos, vel, alarm, warn, cfg, input bvalid, bdata, blast);
  modport gen (input start, sel, pos, vel, alarm, warn, cfg, output bvalid, bdata, blast);
endinterface : eiaf_img_if
`default_nettype wire

/* verilog/eiaf_image.sv */
// Image serializer: sends one snapshot image, low byte first.
// Assumes start comes only while idle.
`timescale 1ns/100ps
`default_nettype none
`include "eiaf_regs.svh"
module eiaf_image import eiaf_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Engine side
  eiaf_img_if.gen  img
);
  logic        active, next_active;     // Sending
  logic [3:0]  idx, next_idx;           // Byte index
  eiaf_sel_t   ssel, next_ssel;         // Snapshot selection
  logic [63:0] spv, next_spv;           // Snapshot velocity and position
  logic [1:0]  sflg, next_sflg;         // Snapshot flags
  logic [95:0] scfg, next_scfg;         // Snapshot configuration
  logic        bv, next_bv;             // Byte valid
  logic [7:0]  bd, next_bd;             // Byte data
  logic        bl, next_bl;             // Last byte

  ////////////////////////////////////////////////////////////
  // Byte of an image at an index
  function automatic logic [7:0] byte_of(input eiaf_sel_t s, input logic [3:0] i);
    logic [15:0] w;
    w = (s == SEL_REV) ? `EIAF_REV_VAL : `EIAF_MAXI_VAL;
    case (s)
      SEL_POS: byte_of = spv[{i[1:0], 3'h0} +: 8];
      SEL_FLG: byte_of = i[2] ? {6'h00, sflg} : spv[{i[1:0], 3'h0} +: 8];
      SEL_VEL: byte_of = spv[{i[2:0], 3'h0} +: 8];
      SEL_CFG: byte_of = scfg[{i, 3'h0} +: 8];
      default: byte_of = w[{i[0], 3'h0} +: 8];
    endcase
  endfunction : byte_of

  ////////////////////////////////////////////////////////////
  // Input images produced onto network
  always_comb begin
    next_active = active;
    next_idx    = idx;
    next_ssel   = ssel;
    next_spv    = spv;
    next_sflg   = sflg;
    next_scfg   = scfg;
    next_bv     = 1'b0;
    next_bl     = 1'b0;
    next_bd     = bd;
    if (img.start) begin
      // Snapshot keeps one image coherent
      next_active = 1'b1;
      next_idx    = 4'h0;
      next_ssel   = img.sel;
      next_spv    = {img.vel, img.pos};
      next_sflg[`EIAF_FLG_ALARM] = img.alarm;
      next_sflg[`EIAF_FLG_WARN]  = img.warn;
      next_scfg   = img.cfg;
    end else if (active) begin
      // One byte per cycle
      next_bv  = 1'b1;
      next_bd  = byte_of(ssel, idx);
      next_bl  = (idx == eiaf_len(ssel) - 4'h1);
      next_idx = idx + 4'h1;
      if (next_bl) begin
        next_active = 1'b0;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active <= 1'b0;
      idx    <= 4'h0;
      ssel   <= SEL_POS;
      spv    <= 64'h0;
      sflg   <= 2'h0;
      scfg   <= 96'h0;
      bv     <= 1'b0;
      bd     <= 8'h00;
      bl     <= 1'b0;
    end else begin
      active <= next_active;
      idx    <= next_idx;
      ssel   <= next_ssel;
      spv    <= next_spv;
      sflg   <= next_sflg;
      scfg   <= next_scfg;
      bv     <= next_bv;
      bd     <= next_bd;
      bl     <= next_bl;
    end
  end

  assign img.bvalid = bv;
  assign img.bdata  = bd;
  assign img.blast  = bl;

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_pos_low;
    (img.start && img.sel == SEL_POS) |-> ##2 (bv && bd == $past(img.pos[7:0], 2));
  endproperty
  a_pos_low: assert property (p_pos_low) else $error("position low byte wrong");
  property p_flg_len;
    (img.start && img.sel == SEL_FLG) |-> ##2 (bv && !bl) [*4] ##1 (bv && bl && bd[7:2] == 6'h00);
  endproperty
  a_flg_len: assert property (p_flg_len) else $error("flag image length wrong");
  property p_vel_low;
    (img.start && img.sel == SEL_VEL) |-> ##6 (bv && bd == $past(img.vel[7:0], 6));
  endproperty
  a_vel_low: assert property (p_vel_low) else $error("velocity byte wrong");
endmodule : eiaf_image
`default_nettype wire

/* verilog/eiaf_conn.sv */
// Connection tracker: one input-only owner and its listeners.
// Assumes open and close pulses never coincide.
`timescale 1ns/100ps
`default_nettype none
`include "eiaf_regs.svh"
module eiaf_conn (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Requests
  input  wire logic       en,
  input  wire logic       open,
  input  wire logic       close,
  input  wire logic [7:0] o2t,
  input  wire logic [7:0] t2o,
  // Results
  output logic            accept,
  output logic            reject,
  output logic            io_active,
  output logic [1:0]      lo_cnt,
  output logic            lo_drop
);
  logic       next_acc, next_rej, next_io, next_drop;  // Next flags
  logic [1:0] next_lo;                                 // Next listener count
  logic       t2o_ok;                                  // Produced image exists

  ////////////////////////////////////////////////////////////
  // Accept, reject and teardown
  always_comb begin
    t2o_ok    = (t2o == `EIAF_INST_POS) || (t2o == `EIAF_INST_FLG) || (t2o == `EIAF_INST_VEL);
    next_acc  = 1'b0;
    next_rej  = 1'b0;
    next_drop = 1'b0;
    next_io   = io_active;
    next_lo   = lo_cnt;
    if (open) begin
      if (en && o2t == `EIAF_PT_INONLY && t2o_ok && !io_active) begin
        next_acc = 1'b1;
        next_io  = 1'b1;
      end else if (en && o2t == `EIAF_PT_LISTEN && t2o_ok && io_active && lo_cnt != `EIAF_LO_MAX) begin
        next_acc = 1'b1;
        next_lo  = lo_cnt + 2'h1;
      end else begin
        next_rej = 1'b1;
      end
    end else if (close) begin
      if (o2t == `EIAF_PT_INONLY && io_active) begin
        next_io   = 1'b0;
        next_lo   = 2'h0;
        next_drop = (lo_cnt != 2'h0);
      end else if (o2t == `EIAF_PT_LISTEN && lo_cnt != 2'h0) begin
        next_lo = lo_cnt - 2'h1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      accept    <= 1'b0;
      reject    <= 1'b0;
      io_active <= 1'b0;
      lo_cnt    <= 2'h0;
      lo_drop   <= 1'b0;
    end else begin
      accept    <= next_acc;
      reject    <= next_rej;
      io_active <= next_io;
      lo_cnt    <= next_lo;
      lo_drop   <= next_drop;
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_io_open;
    (open && en && o2t == `EIAF_PT_INONLY && t2o_ok && !io_active) |=> (accept && io_active);
  endproperty
  a_io_open: assert property (p_io_open) else $error("input-only open refused");
  property p_lo_orphan;
    (open && o2t == `EIAF_PT_LISTEN && !io_active) |=> (reject && lo_cnt == 2'h0);
  endproperty
  a_lo_orphan: assert property (p_lo_orphan) else $error("orphan listener taken");
  property p_io_close;
    (close && !open && o2t == `EIAF_PT_INONLY) |=> (!io_active && lo_cnt == 2'h0);
  endproperty
  a_io_close: assert property (p_io_close) else $error("listeners outlive owner");
endmodule : eiaf_conn
`default_nettype wire

/* verilog/eiaf_framer.sv */
// Assembly framer top: request routing, assembly answers, configuration
// image, connection tracking and software registers.
// Assumes all inputs come from logic on clk; no pin synchronisers needed.
//
// Contract
// - Input-only uses 64h with images 01h-03h
// - Listen-only 65h needs live input-only
// - Closing input-only closes all listeners
// - Position image: 4 bytes, low first
// - Flag image: position, alarm bit0, warning bit1
// - Velocity image: position then velocity
// - Configuration 6Ah: 12 bytes, readable, writable; byte 10 is held at 00h and ignores writes
// - Config: toggle, scaling, units, range bytes
// - Instances and members fixed at build
// - Inputs produced, outputs consumed, network view
// - Only single-attribute read service supported
// - Class attributes: revision 0002h, max 0096h
// - Router steers requests to addressed class
// - Image is attribute 03h of instance
// - Byte 9 range high, byte 11 format
`timescale 1ns/100ps
`default_nettype none
`include "eiaf_regs.svh"
module eiaf_framer import eiaf_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Sensor values
  input  wire logic [31:0] pos_value,
  input  wire logic [31:0] vel_value,
  input  wire logic        alarm_flag,
  input  wire logic        warn_flag,
  // Object requests
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_service,
  input  wire logic [7:0]  req_class,
  input  wire logic [7:0]  req_inst,
  input  wire logic [7:0]  req_attr,
  // Routed elsewhere
  output logic             fwd_valid,
  output logic      [7:0]  fwd_class,
  // Answers
  output logic             rsp_valid,
  output logic      [7:0]  rsp_data,
  output logic             rsp_last,
  output logic             rsp_done,
  output logic      [7:0]  rsp_status,
  // Configuration image writes
  input  wire logic        cfg_wr_valid,
  input  wire logic [3:0]  cfg_wr_index,
  input  wire logic [7:0]  cfg_wr_data,
  // Connections
  input  wire logic        conn_open,
  input  wire logic        conn_close,
  input  wire logic [7:0]  conn_o2t,
  input  wire logic [7:0]  conn_t2o,
  output logic             conn_accept,
  output logic             conn_reject,
  output logic             io_active,
  output logic      [1:0]  listen_count,
  // Interrupt
  output logic             irq
);
  eiaf_st_t    st, next_st;              // Engine state
  logic        start, next_start;        // Serializer start
  eiaf_sel_t   sel, next_sel;            // Selected image
  logic        done, next_done;          // Answer complete
  logic [7:0]  status, next_status;      // Answer status
  logic        fwd, next_fwd;            // Routed pulse
  logic [7:0]  fcls, next_fcls;          // Routed class
  logic        bad;                      // Refused request event
  logic        take;                     // Request taken
  logic [7:0]  cfg_mem [12];             // Configuration bytes
  logic [7:0]  next_cfg [12];            // Next configuration bytes
  logic [95:0] cfg_flat;                 // Flattened image
  logic        ctrl_en, next_en;         // Block enable
  logic [3:0]  istat, next_istat;        // Sticky events
  logic [3:0]  imask, next_imask;        // Event mask
  logic [31:0] next_rdata;               // Read answer
  logic        lo_drop;                  // Listeners dropped

  eiaf_img_if img ();

  ////////////////////////////////////////////////////////////
  // Request engine: decode and answer
  assign req_ready = (st == ST_IDLE) && ctrl_en;
  assign take      = req_valid && req_ready;

  always_comb begin
    next_st     = st;
    next_start  = 1'b0;
    next_sel    = sel;
    next_done   = 1'b0;
    next_status = status;
    next_fwd    = 1'b0;
    next_fcls   = fcls;
    bad         = 1'b0;
    case (st)
      ST_IDLE: begin
        if (take) begin
          next_done   = 1'b1;
          next_start  = 1'b1;
          next_status = `EIAF_ST_OK;
          if (req_class != `EIAF_CLS_ASM) begin
            next_done  = 1'b0;
            next_start = 1'b0;
            next_fwd   = 1'b1;
            next_fcls  = req_class;
          end else if (req_service != `EIAF_SVC_GET) begin
            next_status = `EIAF_ST_NOSVC;
          end else if (req_inst == `EIAF_INST_CLS) begin
            if (req_attr == `EIAF_ATTR_REV) begin
              next_sel = SEL_REV;
            end else if (req_attr == `EIAF_ATTR_MAXI) begin
              next_sel = SEL_MAXI;
            end else begin
              next_status = `EIAF_ST_NOATTR;
            end
          end else begin
            case (req_inst)
              `EIAF_INST_POS: next_sel = SEL_POS;
              `EIAF_INST_FLG: next_sel = SEL_FLG;
              `EIAF_INST_VEL: next_sel = SEL_VEL;
              `EIAF_INST_CFG: next_sel = SEL_CFG;
              default:        next_status = `EIAF_ST_NOOBJ;
            endcase
            if (next_status == `EIAF_ST_OK && req_attr != `EIAF_ATTR_DATA) begin
              next_status = `EIAF_ST_NOATTR;
            end
          end
          // Good reads wait for the image
          if (next_start) begin
            if (next_status == `EIAF_ST_OK) begin
              next_done = 1'b0;
              next_st   = ST_SEND;
            end else begin
              next_start = 1'b0;
              bad        = 1'b1;
            end
          end
        end
      end
      ST_SEND: begin
        // Finish after last byte
        if (img.blast) begin
          next_done = 1'b1;
          next_st   = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // Engine registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st     <= ST_IDLE;
      start  <= 1'b0;
      sel    <= SEL_POS;
      done   <= 1'b0;
      status <= `EIAF_ST_OK;
      fwd    <= 1'b0;
      fcls   <= 8'h00;
    end else begin
      st     <= next_st;
      start  <= next_start;
      sel    <= next_sel;
      done   <= next_done;
      status <= next_status;
      fwd    <= next_fwd;
      fcls   <= next_fcls;
    end
  end

  ////////////////////////////////////////////////////////////
  // Configuration image, written by the master
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      next_cfg[i] = cfg_mem[i];
    end
    if (cfg_wr_valid && cfg_wr_index < `EIAF_LEN_CFG) begin
      next_cfg[cfg_wr_index] = cfg_wr_data;
    end
    next_cfg[`EIAF_CFG_RSV] = 8'h00;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 12; i++) begin
        cfg_mem[i] <= 8'(`EIAF_CFG_RST >> (i * 8));
      end
    end else begin
      for (int i = 0; i < 12; i++) begin
        cfg_mem[i] <= next_cfg[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 12; i++) begin
      cfg_flat[i*8 +: 8] = cfg_mem[i];
    end
  end

  ////////////////////////////////////////////////////////////
  // Serializer and connection tracker
  assign img.start = start;
  assign img.sel   = sel;
  assign img.pos   = pos_value;
  assign img.vel   = vel_value;
  assign img.alarm = alarm_flag;
  assign img.warn  = warn_flag;
  assign img.cfg   = cfg_flat;

  eiaf_image u_image (
    .clk    (clk),
    .resetn (resetn),
    .img    (img.gen)
  );

  eiaf_conn u_conn (
    .clk       (clk),
    .resetn    (resetn),
    .en        (ctrl_en),
    .open      (conn_open),
    .close     (conn_close),
    .o2t       (conn_o2t),
    .t2o       (conn_t2o),
    .accept    (conn_accept),
    .reject    (conn_reject),
    .io_active (io_active),
    .lo_cnt    (listen_count),
    .lo_drop   (lo_drop)
  );

  ////////////////////////////////////////////////////////////
  // Software registers; events win over clears
  always_comb begin
    next_en    = ctrl_en;
    next_imask = imask;
    next_istat = istat;
    next_rdata = 32'h0;
    if (reg_wr && reg_addr == `EIAF_A_CTRL) begin
      next_en = reg_wdata[`EIAF_CTRL_EN];
    end
    if (reg_wr && reg_addr == `EIAF_A_IMASK) begin
      next_imask = reg_wdata[`EIAF_IRQ_W-1:0];
    end
    if (reg_wr && reg_addr == `EIAF_A_ISTAT) begin
      next_istat = istat & ~reg_wdata[`EIAF_IRQ_W-1:0];
    end
    next_istat[`EIAF_IRQ_ACC]  = next_istat[`EIAF_IRQ_ACC] | conn_accept;
    next_istat[`EIAF_IRQ_REJ]  = next_istat[`EIAF_IRQ_REJ] | conn_reject;
    next_istat[`EIAF_IRQ_DROP] = next_istat[`EIAF_IRQ_DROP] | lo_drop;
    next_istat[`EIAF_IRQ_BAD]  = next_istat[`EIAF_IRQ_BAD] | bad;
    // Unmapped reads answer zero
    if (reg_rd) begin
      case (reg_addr)
        `EIAF_A_CTRL:  next_rdata = {31'h0, ctrl_en};
        `EIAF_A_STAT:  next_rdata = {28'h0, listen_count, io_active, st == ST_SEND};
        `EIAF_A_ISTAT: next_rdata = {28'h0, istat};
        `EIAF_A_IMASK: next_rdata = {28'h0, imask};
        `EIAF_A_CFG0:  next_rdata = cfg_flat[31:0];
        `EIAF_A_CFG1:  next_rdata = cfg_flat[63:32];
        `EIAF_A_CFG2:  next_rdata = cfg_flat[95:64];
        default:       next_rdata = 32'h0;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_en   <= `EIAF_CTRL_RST;
      istat     <= 4'h0;
      imask     <= 4'h0;
      reg_rdata <= 32'h0;
    end else begin
      ctrl_en   <= next_en;
      istat     <= next_istat;
      imask     <= next_imask;
      reg_rdata <= next_rdata;
    end
  end

  assign irq        = |(istat & imask);
  assign fwd_valid  = fwd;
  assign fwd_class  = fcls;
  assign rsp_valid  = img.bvalid;
  assign rsp_data   = img.bdata;
  assign rsp_last   = img.blast;
  assign rsp_done   = done;
  assign rsp_status = status;

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_bad_svc;
    (take && req_class == `EIAF_CLS_ASM && req_service != `EIAF_SVC_GET)
      |=> (rsp_done && rsp_status == `EIAF_ST_NOSVC && !rsp_valid);
  endproperty
  a_bad_svc: assert property (p_bad_svc) else $error("unsupported service answered");
  property p_rev;
    (take && req_class == `EIAF_CLS_ASM && req_service == `EIAF_SVC_GET
      && req_inst == `EIAF_INST_CLS && req_attr == `EIAF_ATTR_REV)
      |-> ##3 (rsp_valid && rsp_data == 8'h02) ##1 (rsp_last && rsp_data == 8'h00)
      ##1 (rsp_done && rsp_status == `EIAF_ST_OK);
  endproperty
  a_rev: assert property (p_rev) else $error("revision answer wrong");
  property p_cfg_wr;
    (cfg_wr_valid && cfg_wr_index == 4'h9) |=> (cfg_flat[79:72] == $past(cfg_wr_data));
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("range high byte lost");
  c_route: cover property (take && req_class != `EIAF_CLS_ASM);
  c_cfg_read: cover property (take && req_inst == `EIAF_INST_CFG ##[1:20] rsp_done);
  c_drop: cover property (lo_drop);
endmodule : eiaf_framer
`default_nettype wire

/* test/eiaf_master.sv */
// Originator model: gathers answer bytes of one request, low byte first.
// Assumes the framer's answer stream on the same clock.
`timescale 1ns/100ps
`default_nettype none
module eiaf_master (
  // Clock and request start
  input  wire logic        clk,
  input  wire logic        clr,
  // Answer stream
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_data,
  // Gathered image and byte count
  output logic      [95:0] img,
  output logic      [3:0]  cnt
);
  ////////////////////////////////////////
  // Gather read-back image
  always_ff @(posedge clk) begin
    if (clr) begin
      img <= '0;
      cnt <= '0;
    end else if (rsp_valid) begin
      img[cnt*8 +: 8] <= rsp_data;
      cnt <= cnt + 4'h1;
    end
  end
endmodule : eiaf_master
`default_nettype wire

/* test/tb.sv */
// Bench of the assembly framer: registers, object reads, connections.
// Assumes the originator model eiaf_master for answer gathering.
`timescale 1ns/100ps
`default_nettype none
`include "eiaf_regs.svh"
module tb;
  logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, req_valid = 0, clr = 0;
  logic cfg_wr_valid = 0, conn_open = 0, conn_close = 0, alarm_flag = 1, warn_flag = 0;
  logic [7:0] reg_addr = '0, svc = '0, cls = '0, inst = '0, attr = '0, o2t = '0, t2o = '0, cfg_d = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, pos_value = 32'h1234_5678, vel_value = 32'h9abc_def0;
  logic [7:0] fwd_class, rsp_data, rsp_status;
  logic [3:0] cfg_i = '0, cnt;
  logic [1:0] listen_count;
  logic [95:0] img;
  logic req_ready, fwd_valid, rsp_valid, rsp_last, rsp_done, conn_accept, conn_reject, io_active, irq;
  int n_fail = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  eiaf_framer u_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pos_value,
    .vel_value, .alarm_flag, .warn_flag, .req_valid, .req_ready, .req_service(svc), .req_class(cls),
    .req_inst(inst), .req_attr(attr), .fwd_valid, .fwd_class, .rsp_valid, .rsp_data, .rsp_last,
    .rsp_done, .rsp_status, .cfg_wr_valid, .cfg_wr_index(cfg_i), .cfg_wr_data(cfg_d), .conn_open,
    .conn_close, .conn_o2t(o2t), .conn_t2o(t2o), .conn_accept, .conn_reject, .io_active, .listen_count, .irq);
  eiaf_master u_mst (.clk, .clr, .rsp_valid, .rsp_data, .img, .cnt);
  ////////////////////////////////////////
  task automatic cmp(string n, logic [111:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic end_sim;
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk) begin reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk) begin reg_rd <= 1'h1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'h0;
    #1 cmp("reg_rdata", reg_rdata, e);
  endtask : rd
  // Object request; forwarded classes expect no done
  task automatic get(logic [7:0] s, c, i, t, logic [3:0] n, logic [95:0] e, logic [7:0] st);
    @(posedge clk) begin req_valid <= 1'h1; clr <= 1'h1; svc <= s; cls <= c; inst <= i; attr <= t; end
    @(posedge clk) begin req_valid <= 1'h0; clr <= 1'h0; end
    #1;
    repeat (20) if (rsp_done !== 1'h1 && fwd_valid !== 1'h1) @(posedge clk) #1;
    cmp("answer", {rsp_done, rsp_status, cnt, img}, {c == 8'h04, st, n, e});
  endtask : get
  task automatic conn(logic o, c, logic [7:0] a, b, logic e);
    @(posedge clk) begin conn_open <= o; conn_close <= c; o2t <= a; t2o <= b; end
    @(posedge clk) begin conn_open <= 1'h0; conn_close <= 1'h0; end
    #1 if (o) cmp("conn", {conn_accept, conn_reject}, {e, !e});
  endtask : conn
  ////////////////////////////////////////
  // Hang guard, well beyond the 130 or so cycles needed
  initial begin
    #20000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    rd(`EIAF_A_CTRL, 32'h1);
    rd(8'h40, 32'h0);
    get(8'h0e, 8'h04, 8'h01, 8'h03, 4'h4, pos_value, 8'h00);
    get(8'h0e, 8'h04, 8'h02, 8'h03, 4'h5, {8'h01, pos_value}, 8'h00);
    get(8'h0e, 8'h04, 8'h03, 8'h03, 4'h8, {vel_value, pos_value}, 8'h00);
    @(posedge clk) begin alarm_flag <= 1'h0; warn_flag <= 1'h1; end
    get(8'h0e, 8'h04, 8'h02, 8'h03, 4'h5, {8'h02, pos_value}, 8'h00);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk) begin cfg_wr_valid <= 1'h1; cfg_i <= i[3:0]; cfg_d <= 8'h10 + i[7:0]; end
    end
    @(posedge clk) cfg_wr_valid <= 1'h0;
    get(8'h0e, 8'h04, 8'h6a, 8'h03, 4'hc, 96'h1b00_1918_1716_1514_1312_1110, 8'h00);
    rd(`EIAF_A_CFG2, 32'h1b00_1918);
    get(8'h0e, 8'h04, 8'h00, 8'h01, 4'h2, 96'h0002, 8'h00);
    get(8'h0e, 8'h04, 8'h00, 8'h02, 4'h2, 96'h0096, 8'h00);
    get(8'h10, 8'h04, 8'h01, 8'h03, 4'h0, '0, 8'h08);
    get(8'h0e, 8'h04, 8'h05, 8'h03, 4'h0, '0, 8'h16);
    get(8'h0e, 8'h04, 8'h01, 8'h07, 4'h0, '0, 8'h14);
    get(8'h0e, 8'h02, 8'h01, 8'h01, 4'h0, '0, 8'h00);
    cmp("fwd", {fwd_valid, fwd_class}, 9'h102);
    wr(`EIAF_A_IMASK, 32'h4);
    conn(1'h1, 1'h0, 8'h65, 8'h01, 1'h0);
    conn(1'h1, 1'h0, 8'h64, 8'h04, 1'h0);
    conn(1'h1, 1'h0, 8'h64, 8'h03, 1'h1);
    conn(1'h1, 1'h0, 8'h65, 8'h01, 1'h1);
    conn(1'h1, 1'h0, 8'h65, 8'h02, 1'h1);
    cmp("links", {io_active, listen_count, irq}, 4'hc);
    conn(1'h0, 1'h1, 8'h64, 8'h03, 1'h0);
    @(posedge clk) #1 cmp("links", {io_active, listen_count, irq}, 4'h1);
    wr(`EIAF_A_ISTAT, 32'h4);
    #1 cmp("irq", irq, 1'h0);
    wr(`EIAF_A_CTRL, 32'h0);
    #1 cmp("ready", req_ready, 1'h0);
    conn(1'h1, 1'h0, 8'h64, 8'h03, 1'h0);
    end_sim();
  end
endmodule : tb
`default_nettype wire
